// *** logic/pspc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pspc_top
    import pspc_pkg::*;
(
    input  wire logic       MCLK,
    input  wire logic       RST,
    input  wire logic       SCLK,
    input  wire logic       SDATA,
    input  wire logic       LOAD_STROBE,
    input  wire logic       XTAL_TICK,
    input  wire logic       VCO_TICK,
    output var  logic       REF_PULSE,
    output var  logic       FB_PULSE,
    output var  logic [1:0] CP_SEL,
    output var  logic [3:0] TX_POWER,
    output var  logic       POWER_DOWN,
    output var  logic       MODULUS_32
);

    pspc_top_st_t q;
    pspc_top_st_t d;
    logic         sclk_rise;
    logic         le_rise;
    logic [1:0]   sel;
    logic [7:0]   ref_ratio;
    logic [7:0]   pulse_val;
    logic [6:0]   swal_val;
    logic         pd;

    assign sclk_rise = SCLK && !q.sclk;
    assign le_rise   = LOAD_STROBE && !q.le;
    assign sel       = q.sh[1:0];
    assign ref_ratio = pspc_at_least_one({2'h0, q.regs[SEL_REF][REF_HI:REF_LO]});
    assign pulse_val = q.regs[SEL_PULSE][PULSE_HI:PULSE_LO];
    assign swal_val  = q.regs[SEL_SWAL][SWAL_HI:SWAL_LO];
    assign pd        = q.regs[SEL_PULSE][PD_BIT];

    always_comb begin
        d           = q;
        d.sclk      = SCLK;
        d.le        = LOAD_STROBE;
        d.ref_pulse = 1'b0;
        if (sclk_rise) begin
            d.sh = {q.sh[WORD_BITS-2:0], SDATA};
        end
        if (le_rise) begin
            d.regs[sel] = q.sh[WORD_BITS-1:DATA_LSB];
        end
        if (XTAL_TICK && !pd) begin
            // Ratio may shrink under a running count, so >= not ==
            if ({2'h0, q.ref_cnt} >= ref_ratio - 8'h01) begin
                d.ref_cnt   = 6'h00;
                d.ref_pulse = 1'b1;
            end else begin
                d.ref_cnt = q.ref_cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            q.sclk            <= 1'b0;
            q.le              <= 1'b0;
            q.sh              <= '0;
            q.regs[SEL_REF]   <= RST_REF;
            q.regs[SEL_PULSE] <= RST_PULSE;
            q.regs[SEL_SWAL]  <= RST_SWAL;
            q.regs[SEL_TXP]   <= RST_TXP;
            q.ref_cnt         <= 6'h00;
            q.ref_pulse       <= 1'b0;
        end else begin
            q <= d;
        end
    end

    pspc_fb_div u_fb (
        .clk      (MCLK),
        .rst      (RST),
        .vco_tick (VCO_TICK),
        .run      (!pd),
        .mod32    (q.regs[SEL_SWAL][MOD_BIT]),
        .pulse    (pulse_val),
        .swallow  (swal_val),
        .fb_pulse (FB_PULSE)
    );

    assign REF_PULSE  = q.ref_pulse;
    assign CP_SEL     = q.regs[SEL_REF][CP_HI:CP_LO];
    assign TX_POWER   = q.regs[SEL_TXP][TXP_HI:TXP_LO];
    assign POWER_DOWN = pd;
    assign MODULUS_32 = q.regs[SEL_SWAL][MOD_BIT];

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_shift_in: assert property (
        sclk_rise |=> q.sh == {$past(q.sh[WORD_BITS-2:0]), $past(SDATA)})
        else $error("serial bit not shifted in on clock rise");

    a_hold_latch: assert property (
        !le_rise |=> $stable(q.regs))
        else $error("latched registers changed without load strobe");

    a_load_word: assert property (
        le_rise |=> q.regs[$past(sel)] == $past(q.sh[WORD_BITS-1:DATA_LSB]))
        else $error("selected register not loaded with shifted word");

    a_keep_other: assert property (
        (le_rise && sel != SEL_REF) |=> $stable(q.regs[SEL_REF]))
        else $error("unselected register was overwritten");

    a_cp_load: assert property (
        (le_rise && sel == SEL_REF) |=> CP_SEL == $past(q.sh[9:8]))
        else $error("pump current not taken from data bits 8:7");

    a_pd_load: assert property (
        (le_rise && sel == SEL_PULSE) |=> POWER_DOWN == $past(q.sh[10]))
        else $error("power-down not taken from data bit 9");

    a_pd_quiet: assert property (
        (POWER_DOWN && $past(POWER_DOWN)) |-> !REF_PULSE)
        else $error("reference divider ran in power-down");

    a_ref_one: assert property (
        (ref_ratio == 8'h01 && XTAL_TICK && !pd) |=> REF_PULSE)
        else $error("ratio one did not pass every crystal tick");

    a_ref_cause: assert property (
        REF_PULSE |-> (q.ref_cnt == 6'h00 && $past(XTAL_TICK)))
        else $error("reference pulse without crystal tick");

    c_load_pulse: cover property (le_rise && sel == SEL_PULSE);
    c_ref_out: cover property (REF_PULSE && ref_ratio == 8'h0a);
    c_fb_out: cover property (FB_PULSE);
    c_pd_on: cover property ($rose(POWER_DOWN));

endmodule : pspc_top
`default_nettype wire

// *** logic/pspc_pkg.sv ***
`default_nettype none
package pspc_pkg;

    localparam int          WORD_BITS = 11;
    localparam int          DATA_LSB  = 2;

    localparam logic [1:0]  SEL_REF   = 2'h0;
    localparam logic [1:0]  SEL_PULSE = 2'h1;
    localparam logic [1:0]  SEL_SWAL  = 2'h2;
    localparam logic [1:0]  SEL_TXP   = 2'h3;

    // Field positions, data bit 1 is the lowest
    localparam int          CP_HI     = 8;
    localparam int          CP_LO     = 7;
    localparam int          REF_HI    = 6;
    localparam int          REF_LO    = 1;
    localparam int          PD_BIT    = 9;
    localparam int          PULSE_HI  = 8;
    localparam int          PULSE_LO  = 1;
    localparam int          MOD_BIT   = 8;
    localparam int          SWAL_HI   = 7;
    localparam int          SWAL_LO   = 1;
    localparam int          TXP_HI    = 6;
    localparam int          TXP_LO    = 3;

    // Reset contents: ratio 10, pulse 10, modulus 32, swallow 0
    localparam logic [9:1]  RST_REF   = 9'h00a;
    localparam logic [9:1]  RST_PULSE = 9'h00a;
    localparam logic [9:1]  RST_SWAL  = 9'h080;
    localparam logic [9:1]  RST_TXP   = 9'h000;
    localparam logic [7:0]  RST_BCNT  = 8'h0a;

    localparam logic [5:0]  MOD_LO    = 6'h10;
    localparam logic [5:0]  MOD_HI    = 6'h20;

    typedef logic [9:1] pspc_data_t;

    typedef enum logic {PH_SWALLOW, PH_PLAIN} pspc_phase_t;

    typedef struct packed {
        logic                   sclk;
        logic                   le;
        logic [WORD_BITS-1:0]   sh;
        pspc_data_t [3:0]       regs;
        logic [5:0]             ref_cnt;
        logic                   ref_pulse;
    } pspc_top_st_t;

    typedef struct packed {
        pspc_phase_t            ph;
        logic [5:0]             pre;
        logic [6:0]             a;
        logic [7:0]             b;
        logic                   fb;
    } pspc_fb_st_t;

    // Zero ratio behaves as one
    function automatic logic [7:0] pspc_at_least_one(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : v;
    endfunction : pspc_at_least_one

endpackage : pspc_pkg
`default_nettype wire

// *** logic/pspc_fb_div.sv ***
`timescale 1ns/1ps
`default_nettype none
module pspc_fb_div
    import pspc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       vco_tick,
    input  wire logic       run,
    input  wire logic       mod32,
    input  wire logic [7:0] pulse,
    input  wire logic [6:0] swallow,
    output var  logic       fb_pulse
);

    pspc_fb_st_t q;
    pspc_fb_st_t d;
    logic [5:0]  modv;
    logic [5:0]  lim;
    logic        wrap;

    always_comb begin
        d    = q;
        d.fb = 1'b0;
        wrap = 1'b0;
        modv = mod32 ? MOD_HI : MOD_LO;
        case (q.ph)
            PH_SWALLOW: lim = modv;
            PH_PLAIN: lim = modv - 6'h01;
            default: lim = modv - 6'h01;
        endcase
        if (run && vco_tick) begin
            // Compare with >= so a modulus change never overruns
            if (q.pre >= lim) begin
                d.pre = 6'h00;
                wrap  = 1'b1;
            end else begin
                d.pre = q.pre + 6'h01;
            end
        end
        if (wrap) begin
            if (q.b <= 8'h01) begin
                d.a  = swallow;
                d.b  = pspc_at_least_one(pulse);
                d.ph = (swallow == 7'h00) ? PH_PLAIN : PH_SWALLOW;
                d.fb = 1'b1;
            end else begin
                d.b = q.b - 8'h01;
                if (q.ph == PH_SWALLOW) begin
                    d.a = q.a - 7'h01;
                    if (q.a == 7'h01) begin
                        d.ph = PH_PLAIN;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q.ph  <= PH_PLAIN;
            q.pre <= 6'h00;
            q.a   <= 7'h00;
            q.b   <= RST_BCNT;
            q.fb  <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign fb_pulse = q.fb;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_swallow_extra: assert property (
        (run && vco_tick && q.ph == PH_SWALLOW && q.pre == modv - 6'h01)
        |=> q.pre == $past(modv))
        else $error("swallow phase did not divide by P+1");

    a_plain_wrap: assert property (
        (run && vco_tick && q.ph == PH_PLAIN && q.pre == modv - 6'h01)
        |=> q.pre == 6'h00)
        else $error("plain phase did not divide by P");

    a_reload_pulse: assert property (
        q.fb |-> q.b == pspc_at_least_one($past(pulse)))
        else $error("pulse counter not reloaded at wrap");

    a_swallow_live: assert property (
        q.ph == PH_SWALLOW |-> q.a != 7'h00)
        else $error("swallow phase with empty swallow counter");

    c_fb_swallow: cover property (q.fb && q.ph == PH_SWALLOW);

endmodule : pspc_fb_div
`default_nettype wire

// *** dv/pspc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pspc_host_model (
    input  wire logic MCLK,
    output var  logic SCLK,
    output var  logic SDATA,
    output var  logic LOAD_STROBE
);
    initial begin
        SCLK        = 1'b0;
        SDATA       = 1'b0;
        LOAD_STROBE = 1'b0;
    end
    task automatic shift_bit(input logic b);
        @(posedge MCLK);
        SDATA <= b;
        SCLK  <= 1'b1;
        @(posedge MCLK);
        SCLK  <= 1'b0;
    endtask : shift_bit
    task automatic shift_word(input logic [10:0] w);
        for (int i = 10; i >= 0; i--) begin
            shift_bit(w[i]);
        end
    endtask : shift_word
    task automatic load();
        @(posedge MCLK);
        SDATA       <= ~SDATA;
        @(posedge MCLK);
        LOAD_STROBE <= 1'b1;
        @(posedge MCLK);
        @(posedge MCLK);
        LOAD_STROBE <= 1'b0;
    endtask : load
endmodule : pspc_host_model
`default_nettype wire

// *** dv/tb_pspc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_pspc_top;
    logic        MCLK, RST, SCLK, SDATA, LOAD_STROBE, XTAL_TICK, VCO_TICK;
    logic        REF_PULSE, FB_PULSE, POWER_DOWN, MODULUS_32;
    logic [1:0]  CP_SEL;
    logic [3:0]  TX_POWER;
    int          error_cnt, compares, skip_r, skip_n, rcnt, ncnt;
    logic [15:0] exp_r, exp_n;
    logic [7:0]  cfg_q[$];
    logic [1:0]  m_cp;
    logic [3:0]  m_tx;
    logic [5:0]  m_r;
    logic [7:0]  m_b;
    logic [6:0]  m_a;
    logic        m_pd, m_mod, ticks_on, le_q;
    logic [31:0] rng, tk, gb;
    logic [9:1]  tab_d[9] = '{9'h1c7, 9'h1fb, 9'h000, 9'h100, 9'h07f,
                              9'h185, 9'h0c0, 9'h103, 9'h005};
    logic [1:0]  tab_s[9] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0,
                              2'h2, 2'h1};

    initial begin
        MCLK = 1'b0;
        forever #5 MCLK = ~MCLK;
    end

    pspc_top DUT (.MCLK(MCLK), .RST(RST), .SCLK(SCLK), .SDATA(SDATA),
        .LOAD_STROBE(LOAD_STROBE), .XTAL_TICK(XTAL_TICK),
        .VCO_TICK(VCO_TICK), .REF_PULSE(REF_PULSE), .FB_PULSE(FB_PULSE),
        .CP_SEL(CP_SEL), .TX_POWER(TX_POWER), .POWER_DOWN(POWER_DOWN),
        .MODULUS_32(MODULUS_32));
    pspc_host_model u_host (.MCLK(MCLK), .SCLK(SCLK), .SDATA(SDATA),
        .LOAD_STROBE(LOAD_STROBE));

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic cmp_cfg(input logic [7:0] e);
        logic [7:0] g;
        g = {CP_SEL, TX_POWER, POWER_DOWN, MODULUS_32};
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch config expected %h seen %h", e, g);
        end
    endtask : cmp_cfg

    task automatic cmp_per(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %0d seen %0d", nm, e, g);
        end
    endtask : cmp_per

    task automatic put(input logic [1:0] s, input logic [9:1] d);
        u_host.shift_word({d, s});
        case (s)
            2'h0: {m_cp, m_r} = d[8:1];
            2'h1: {m_pd, m_b} = d;
            2'h2: {m_mod, m_a} = d[8:1];
            default: m_tx = d[6:3];
        endcase
        exp_r = (m_r == 6'h00) ? 16'h0001 : {10'h000, m_r};
        exp_n = {8'h00, m_b} * (m_mod ? 16'h0020 : 16'h0010) + m_a;
        cfg_q.push_back({m_cp, m_tx, m_pd, m_mod});
        u_host.load();
    endtask : put

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    always @(posedge MCLK) begin
        if (ticks_on) begin
            tk = xs();
            XTAL_TICK <= tk[0];
            VCO_TICK  <= tk[5];
        end
    end

    // Periods counted in ticks; power-down ticks do not count
    always @(posedge MCLK) begin
        if (RST === 1'b1) begin
            rcnt = 0;
            ncnt = 0;
        end else begin
            if (REF_PULSE === 1'b1) begin
                if (skip_r > 0) skip_r--;
                else cmp_per("ref_period", exp_r, rcnt[15:0]);
                rcnt = 0;
            end
            if (FB_PULSE === 1'b1) begin
                if (skip_n > 0) skip_n--;
                else cmp_per("fb_period", exp_n, ncnt[15:0]);
                ncnt = 0;
            end
            if (XTAL_TICK && POWER_DOWN === 1'b0) rcnt++;
            if (VCO_TICK && POWER_DOWN === 1'b0) ncnt++;
        end
    end

    always @(posedge MCLK) begin
        if (LOAD_STROBE === 1'b1 && le_q === 1'b0) begin
            @(posedge MCLK);
            #1;
            cmp_cfg(cfg_q.pop_front()); // decode
        end
        le_q = LOAD_STROBE;
    end

    initial begin
        repeat (30000) @(posedge MCLK);
        error_cnt++;
        $display("watchdog expired");
        report_and_stop();
    end

    initial begin
        {RST, ticks_on, le_q, XTAL_TICK, VCO_TICK} = 5'h10;
        {error_cnt, compares, skip_r, skip_n} = '0;
        rng = 32'h00000026;
        {m_cp, m_tx, m_pd, m_mod, m_r, m_b, m_a} = {8'h01, 6'h0a, 8'h0a, 7'h00};
        exp_r = 16'h000a;
        exp_n = 16'h0140;
        repeat (16) @(posedge MCLK);
        RST <= 1'b0;
        @(posedge MCLK);
        #1;
        cmp_cfg({m_cp, m_tx, m_pd, m_mod}); // reset values
        @(posedge MCLK);
        ticks_on <= 1'b1;
        repeat (1600) @(posedge MCLK);
        $display("test defaults done");
        ticks_on <= 1'b0;
        // pulse count nonzero, not below swallow
        for (int i = 0; i < 9; i++) begin
            put(tab_s[i], tab_d[i]);
        end
        repeat (8) @(posedge MCLK);
        skip_r = 1;
        skip_n = 1;
        ticks_on <= 1'b1;
        repeat (2000) @(posedge MCLK);
        $display("test divider done");
        for (int i = 0; i < 3; i++) begin
            gb = xs();
            u_host.shift_bit(gb[3]);
        end
        put(2'h3, 9'h1fb);
        for (int i = 0; i < 7; i++) begin
            gb = xs();
            u_host.shift_bit(gb[4]);
        end
        repeat (4) @(posedge MCLK);
        #1;
        cmp_cfg({m_cp, m_tx, m_pd, m_mod}); // latches held
        $display("test shift noise done");
        put(2'h1, 9'h105);
        repeat (800) @(posedge MCLK);
        put(2'h1, 9'h005);
        repeat (1500) @(posedge MCLK);
        $display("test power down done");
        report_and_stop();
    end
endmodule : tb_pspc_top
`default_nettype wire
